// File: hw/rtcm_pkg.sv
// Shared constants and types for the two-wire host that drives the clock chip.
// Assumes a 20 MHz system clock and a bus with pull-ups on both lines.
package rtcm_pkg;

  // Bus addressing of the clock chip.
  localparam logic [6:0] SLV_ADDR    = 7'h51;
  localparam logic [6:0] TEST_ADDR_A = 7'h49;
  localparam logic [6:0] TEST_ADDR_B = 7'h4a;
  localparam logic       RW_READ     = 1'b1;
  localparam logic       RW_WRITE    = 1'b0;

  // Bit timing: one bit is four quarter phases of the link clock.
  localparam int CLK_MHZ = 20;
  localparam int TQ_NS   = 2500;
  localparam int TQ_CYC  = (TQ_NS * CLK_MHZ + 999) / 1000;
  localparam int TQ_W    = 16;

  // Quarter phases within one bit slot.
  localparam logic [1:0] PH_SETUP = 2'h0;
  localparam logic [1:0] PH_RISE  = 2'h1;
  localparam logic [1:0] PH_HIGH  = 2'h2;
  localparam logic [1:0] PH_FALL  = 2'h3;

  // Reset values, byte constants and bit and clock-pulse counts.
  localparam logic [1:0] PIN_IDLE  = 2'h3;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE  = 8'h01;
  localparam logic [2:0] BIT_LAST  = 3'h7;
  localparam logic [3:0] BYTE_RISES = 4'h8;

  // One transfer request: direction, pointer handling, pointer and byte count.
  typedef struct packed {
    logic       rd;
    logic       set_ptr;
    logic [7:0] ptr;
    logic [7:0] len;
  } rtcm_cmd_t;

  // Completion report of one transfer.
  typedef struct packed {
    logic done;
    logic nack;
  } rtcm_resp_t;

  // Sampled bus lines.
  typedef struct packed {
    logic scl;
    logic sda;
  } rtcm_pins_t;

  typedef enum logic [2:0] {S_IDLE, S_START, S_TX, S_ACK_RX, S_RX, S_ACK_TX, S_STOP} rtcm_state_t;
  typedef enum logic [1:0] {SQ_ADDR, SQ_PTR, SQ_DATA} rtcm_seq_t;
  typedef enum logic [1:0] {COND_NONE, COND_START, COND_STOP} rtcm_cond_t;

endpackage

// File: hw/rtcm_sync.sv
// Three-stage input synchroniser for the bus lines.
// Assumes inputs arrive asynchronously to clk; output follows once stages two and three agree.
`timescale 1ns/100ps
module rtcm_sync #(
  parameter int             W   = 2,
  parameter logic [W-1:0]   RST = '1
) (
  input  logic         clk,
  input  logic         reset,
  input  logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  logic [W-1:0] out_d;

  //////////////////////////////////////////////////////////////////////////////
  // A bit only moves when the last two stages agree, which rejects a one-cycle
  // glitch at the cost of one more cycle of latency.
  always_comb begin
    out_d = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & out_q);
  end

  // Stage one is read by stage two only.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_q  <= RST;
      s2_q  <= RST;
      s3_q  <= RST;
      out_q <= RST;
    end else begin
      s1_q  <= din;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign dout = out_q;

endmodule

// File: hw/rtcm_i2c_host.sv
// Two-wire bus master that writes and reads the registers of the clock chip.
// Assumes open-drain pads outside; the bench resolves each line from the enables.
`timescale 1ns/100ps

module rtcm_i2c_host #(
  parameter logic [6:0] SLAVE_ADDR = rtcm_pkg::SLV_ADDR,
  parameter int         TQ_CYCLES  = rtcm_pkg::TQ_CYC
) (
  input  logic                 clk,
  input  logic                 reset,
  input  logic                 cmd_valid,
  output logic                 cmd_ready,
  input  rtcm_pkg::rtcm_cmd_t  cmd,
  input  logic                 wr_valid,
  output logic                 wr_ready,
  input  logic [7:0]           wr_data,
  output logic                 rd_valid,
  output logic [7:0]           rd_data,
  output rtcm_pkg::rtcm_resp_t resp,
  output logic                 busy,
  input  logic                 scl_i,
  output logic                 scl_o,
  output logic                 scl_oe,
  input  logic                 sda_i,
  output logic                 sda_o,
  output logic                 sda_oe
);

  rtcm_pkg::rtcm_pins_t  pin_s;
  rtcm_pkg::rtcm_state_t st_q, st_d;
  rtcm_pkg::rtcm_seq_t   seq_q, seq_d;
  rtcm_pkg::rtcm_cmd_t   cmd_q, cmd_d;
  rtcm_pkg::rtcm_resp_t  resp_q, resp_d;
  rtcm_pkg::rtcm_cond_t  cond_q, cond_d;
  logic [rtcm_pkg::TQ_W-1:0] tq_q, tq_d;
  logic [1:0]            ph_q, ph_d;
  logic [2:0]            bit_q, bit_d;
  logic [7:0]            sh_q, sh_d;
  logic [7:0]            cnt_q, cnt_d;
  logic [7:0]            rdd_q, rdd_d;
  logic                  rdv_q, rdv_d;
  logic                  dir_q, dir_d;
  logic                  rs_q, rs_d;
  logic                  nack_q, nack_d;
  logic                  err_q, err_d;
  logic                  scl_oe_q, scl_oe_d;
  logic                  sda_oe_q, sda_oe_d;
  logic                  tick;
  logic                  adv;
  logic                  want_wr;
  logic                  wait_wr;
  logic                  reserved;
  logic [3:0]            hb_q;

  //////////////////////////////////////////////////////////////////////////////
  // Input sampling of both lines.
  rtcm_sync #(.W(2), .RST(rtcm_pkg::PIN_IDLE)) u_sync (
    .clk   (clk),
    .reset (reset),
    .din   ({scl_i, sda_i}),
    .dout  (pin_s)
  );

  // A build for a test-mode address never touches the bus at all.
  assign reserved = (SLAVE_ADDR == rtcm_pkg::TEST_ADDR_A) ||
                    (SLAVE_ADDR == rtcm_pkg::TEST_ADDR_B);

  // Phase pacing; a slave holding the clock low stretches the rise phase.
  assign tick    = (tq_q == rtcm_pkg::TQ_W'(TQ_CYCLES - 1));
  assign want_wr = !cmd_q.rd && (seq_q != rtcm_pkg::SQ_ADDR) && (cnt_q != rtcm_pkg::BYTE_ZERO);
  assign wait_wr = (st_q == rtcm_pkg::S_ACK_RX) && (ph_q == rtcm_pkg::PH_FALL) &&
                   !nack_q && want_wr && !wr_valid;
  assign adv     = tick && !((ph_q == rtcm_pkg::PH_RISE) && !pin_s.scl) && !wait_wr;

  // Handshakes; waiting for write data parks the bus with the clock held low.
  assign cmd_ready = (st_q == rtcm_pkg::S_IDLE);
  assign wr_ready  = (st_q == rtcm_pkg::S_ACK_RX) && (ph_q == rtcm_pkg::PH_FALL) &&
                     tick && !nack_q && want_wr;
  assign busy      = (st_q != rtcm_pkg::S_IDLE);

  //////////////////////////////////////////////////////////////////////////////
  // Transfer sequencer: next values.
  always_comb begin
    st_d   = st_q;
    seq_d  = seq_q;
    cmd_d  = cmd_q;
    ph_d   = ph_q;
    bit_d  = bit_q;
    sh_d   = sh_q;
    cnt_d  = cnt_q;
    dir_d  = dir_q;
    rs_d   = rs_q;
    nack_d = nack_q;
    err_d  = err_q;
    rdd_d  = rdd_q;
    rdv_d  = 1'b0;
    resp_d = '0;
    tq_d   = (st_q == rtcm_pkg::S_IDLE || tick) ? '0 : rtcm_pkg::TQ_W'(tq_q + 1'b1);
    if (adv && st_q != rtcm_pkg::S_IDLE) begin
      ph_d = ph_q + 2'h1;
    end
    case (st_q)
      rtcm_pkg::S_IDLE: begin
        ph_d = rtcm_pkg::PH_SETUP;
        if (cmd_valid) begin
          cmd_d  = cmd;
          rs_d   = 1'b0;
          err_d  = 1'b0;
          nack_d = 1'b0;
          dir_d  = cmd.rd & ~cmd.set_ptr;
          cnt_d  = (cmd.rd && cmd.len == rtcm_pkg::BYTE_ZERO) ? rtcm_pkg::BYTE_ONE : cmd.len;
          if (reserved) begin
            resp_d = '{done: 1'b1, nack: 1'b1};
          end else begin
            st_d = rtcm_pkg::S_START;
          end
        end
      end
      rtcm_pkg::S_START: begin
        if (adv && ph_q == rtcm_pkg::PH_FALL) begin
          st_d  = rtcm_pkg::S_TX;
          sh_d  = {SLAVE_ADDR, dir_q};
          bit_d = 3'h0;
          seq_d = rtcm_pkg::SQ_ADDR;
        end
      end
      rtcm_pkg::S_TX: begin
        if (adv && ph_q == rtcm_pkg::PH_FALL) begin
          sh_d  = {sh_q[6:0], 1'b0};
          bit_d = bit_q + 3'h1;
          if (bit_q == rtcm_pkg::BIT_LAST) begin
            st_d = rtcm_pkg::S_ACK_RX;
          end
        end
      end
      rtcm_pkg::S_ACK_RX: begin
        if (adv && ph_q == rtcm_pkg::PH_HIGH) begin
          nack_d = pin_s.sda;
        end
        if (adv && ph_q == rtcm_pkg::PH_FALL) begin
          if (nack_q) begin
            err_d = 1'b1;
            st_d  = rtcm_pkg::S_STOP;
          end else if (seq_q == rtcm_pkg::SQ_ADDR && dir_q) begin
            st_d  = rtcm_pkg::S_RX;
            seq_d = rtcm_pkg::SQ_DATA;
          end else if (seq_q == rtcm_pkg::SQ_ADDR) begin
            st_d  = rtcm_pkg::S_TX;
            sh_d  = cmd_q.ptr;
            seq_d = rtcm_pkg::SQ_PTR;
          end else if (cmd_q.rd) begin
            st_d  = rtcm_pkg::S_START;
            rs_d  = 1'b1;
            dir_d = rtcm_pkg::RW_READ;
          end else if (cnt_q != rtcm_pkg::BYTE_ZERO) begin
            st_d  = rtcm_pkg::S_TX;
            sh_d  = wr_data;
            seq_d = rtcm_pkg::SQ_DATA;
            cnt_d = cnt_q - rtcm_pkg::BYTE_ONE;
          end else begin
            st_d = rtcm_pkg::S_STOP;
          end
        end
      end
      rtcm_pkg::S_RX: begin
        if (adv && ph_q == rtcm_pkg::PH_HIGH) begin
          sh_d = {sh_q[6:0], pin_s.sda};
        end
        if (adv && ph_q == rtcm_pkg::PH_FALL) begin
          bit_d = bit_q + 3'h1;
          if (bit_q == rtcm_pkg::BIT_LAST) begin
            st_d  = rtcm_pkg::S_ACK_TX;
            rdd_d = sh_q;
            rdv_d = 1'b1;
            cnt_d = cnt_q - rtcm_pkg::BYTE_ONE;
          end
        end
      end
      rtcm_pkg::S_ACK_TX: begin
        if (adv && ph_q == rtcm_pkg::PH_FALL) begin
          st_d = (cnt_q != rtcm_pkg::BYTE_ZERO) ? rtcm_pkg::S_RX : rtcm_pkg::S_STOP;
        end
      end
      rtcm_pkg::S_STOP: begin
        if (adv && ph_q == rtcm_pkg::PH_FALL) begin
          st_d   = rtcm_pkg::S_IDLE;
          resp_d = '{done: 1'b1, nack: err_q};
        end
      end
      default: begin
        st_d = rtcm_pkg::S_IDLE;
      end
    endcase
  end

  // Transfer sequencer: registers.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q   <= rtcm_pkg::S_IDLE;
      seq_q  <= rtcm_pkg::SQ_ADDR;
      cmd_q  <= '0;
      tq_q   <= '0;
      ph_q   <= rtcm_pkg::PH_SETUP;
      bit_q  <= 3'h0;
      sh_q   <= rtcm_pkg::BYTE_ZERO;
      cnt_q  <= rtcm_pkg::BYTE_ZERO;
      dir_q  <= rtcm_pkg::RW_WRITE;
      rs_q   <= 1'b0;
      nack_q <= 1'b0;
      err_q  <= 1'b0;
      rdd_q  <= rtcm_pkg::BYTE_ZERO;
      rdv_q  <= 1'b0;
      resp_q <= '0;
    end else begin
      st_q   <= st_d;
      seq_q  <= seq_d;
      cmd_q  <= cmd_d;
      tq_q   <= tq_d;
      ph_q   <= ph_d;
      bit_q  <= bit_d;
      sh_q   <= sh_d;
      cnt_q  <= cnt_d;
      dir_q  <= dir_d;
      rs_q   <= rs_d;
      nack_q <= nack_d;
      err_q  <= err_d;
      rdd_q  <= rdd_d;
      rdv_q  <= rdv_d;
      resp_q <= resp_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Line drivers: an enable pulls the line low, otherwise the pull-up wins.
  always_comb begin
    scl_oe_d = 1'b0;
    sda_oe_d = 1'b0;
    cond_d   = rtcm_pkg::COND_NONE;
    case (st_q)
      rtcm_pkg::S_IDLE: begin
        scl_oe_d = 1'b0;
        sda_oe_d = 1'b0;
      end
      rtcm_pkg::S_START: begin
        scl_oe_d = (ph_q == rtcm_pkg::PH_SETUP && rs_q) || ph_q == rtcm_pkg::PH_FALL;
        sda_oe_d = (ph_q == rtcm_pkg::PH_HIGH) || (ph_q == rtcm_pkg::PH_FALL);
        cond_d   = (ph_q == rtcm_pkg::PH_HIGH) ? rtcm_pkg::COND_START : rtcm_pkg::COND_NONE;
      end
      rtcm_pkg::S_TX: begin
        scl_oe_d = (ph_q == rtcm_pkg::PH_SETUP) || (ph_q == rtcm_pkg::PH_FALL);
        sda_oe_d = !sh_q[7];
      end
      rtcm_pkg::S_ACK_RX, rtcm_pkg::S_RX: begin
        scl_oe_d = (ph_q == rtcm_pkg::PH_SETUP) || (ph_q == rtcm_pkg::PH_FALL);
        sda_oe_d = 1'b0;
      end
      rtcm_pkg::S_ACK_TX: begin
        scl_oe_d = (ph_q == rtcm_pkg::PH_SETUP) || (ph_q == rtcm_pkg::PH_FALL);
        sda_oe_d = (cnt_q != rtcm_pkg::BYTE_ZERO);
      end
      rtcm_pkg::S_STOP: begin
        scl_oe_d = (ph_q == rtcm_pkg::PH_SETUP);
        sda_oe_d = (ph_q == rtcm_pkg::PH_SETUP) || (ph_q == rtcm_pkg::PH_RISE);
        cond_d   = (ph_q == rtcm_pkg::PH_HIGH) ? rtcm_pkg::COND_STOP : rtcm_pkg::COND_NONE;
      end
      default: begin
        scl_oe_d = 1'b0;
        sda_oe_d = 1'b0;
      end
    endcase
  end

  // Registered drives keep glitches off the open-drain pads.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      cond_q   <= rtcm_pkg::COND_NONE;
    end else begin
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
      cond_q   <= cond_d;
    end
  end

  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign scl_oe   = scl_oe_q;
  assign sda_oe   = sda_oe_q;
  assign rd_valid = rdv_q;
  assign rd_data  = rdd_q;
  assign resp     = resp_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks. The helper counts clock releases within one byte slot.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hb_q <= 4'h0;
    end else if (st_q == rtcm_pkg::S_ACK_RX || st_q == rtcm_pkg::S_ACK_TX) begin
      hb_q <= 4'h0;
    end else if ((st_q == rtcm_pkg::S_TX || st_q == rtcm_pkg::S_RX) &&
                 adv && ph_q == rtcm_pkg::PH_RISE) begin
      hb_q <= hb_q + 4'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_nack_stop;
    (st_q == rtcm_pkg::S_STOP) ##[1:1000] (resp_q.done && resp_q.nack);
  endsequence

  sequence s_restart_open;
    (scl_oe_q && !sda_oe_q) ##1 (scl_oe_q && !sda_oe_q);
  endsequence

  a_start_cond: assert property (
    ($rose(sda_oe_q) && !scl_oe_q) |-> (cond_q == rtcm_pkg::COND_START))
    else $error("Data pulled low with clock high outside a start.");
  a_stop_cond: assert property (
    ($fell(sda_oe_q) && !scl_oe_q) |-> (cond_q == rtcm_pkg::COND_STOP))
    else $error("Data released with clock high outside a stop.");
  a_restart_form: assert property (
    ($rose(st_q == rtcm_pkg::S_START) && rs_q) |=> s_restart_open)
    else $error("Repeated start did not open with clock low and data released.");
  a_byte_bits: assert property (
    $rose(st_q == rtcm_pkg::S_ACK_RX || st_q == rtcm_pkg::S_ACK_TX) |-> (hb_q == rtcm_pkg::BYTE_RISES))
    else $error("Byte slot did not carry eight clock pulses.");
  a_sda_steady: assert property (
    ($changed(sda_oe_q) && !scl_oe_q && !$past(scl_oe_q)) |-> (cond_q != rtcm_pkg::COND_NONE))
    else $error("Data changed while clock high without a condition.");
  a_rx_sample: assert property (
    (st_q == rtcm_pkg::S_RX && adv && ph_q == rtcm_pkg::PH_HIGH) |-> (pin_s.scl && !scl_oe_q))
    else $error("Received bit sampled while clock not high.");
  a_ack_release: assert property (
    (st_q == rtcm_pkg::S_ACK_RX && $past(st_q) == rtcm_pkg::S_ACK_RX) |-> !sda_oe_q)
    else $error("Host drove data during slave acknowledge.");
  a_master_ack: assert property (
    (st_q == rtcm_pkg::S_ACK_TX && $past(st_q) == rtcm_pkg::S_ACK_TX) |->
      (sda_oe_q == (cnt_q != rtcm_pkg::BYTE_ZERO)))
    else $error("Host acknowledge does not match remaining byte count.");
  a_rx_release: assert property (
    (st_q == rtcm_pkg::S_RX && $past(st_q) == rtcm_pkg::S_RX) |-> !sda_oe_q)
    else $error("Host held data while slave transmits.");
  a_nack_stop: assert property (
    (st_q == rtcm_pkg::S_ACK_RX && adv && ph_q == rtcm_pkg::PH_FALL && nack_q) |=> s_nack_stop)
    else $error("Missing acknowledge did not end in a failed stop.");
  a_addr_byte: assert property (
    ($rose(st_q == rtcm_pkg::S_TX) && seq_q == rtcm_pkg::SQ_ADDR) |-> (sh_q == {SLAVE_ADDR, dir_q}))
    else $error("First byte is not address plus direction.");
  a_ptr_byte: assert property (
    ($rose(st_q == rtcm_pkg::S_TX) && seq_q == rtcm_pkg::SQ_PTR) |->
      (sh_q == cmd_q.ptr && !(cmd_q.rd && !cmd_q.set_ptr)))
    else $error("Pointer byte wrong or sent in a simplified read.");
  a_idle_bus: assert property (
    (st_q == rtcm_pkg::S_IDLE && $past(st_q) == rtcm_pkg::S_IDLE) |-> (!sda_oe_q && !scl_oe_q))
    else $error("Bus line pulled while idle.");
  a_test_addr: assert property (
    (st_q == rtcm_pkg::S_START) |-> !reserved)
    else $error("Transfer started toward a test-mode address.");

endmodule

// File: sim/rtcm_dev_model.sv
// Behavioural model of the clock chip's two-wire slave port with a 256-byte register space.
// Assumes resolved open-drain lines with pull-ups; pull outputs are high while the model drives.
`timescale 1ns/100ps
module rtcm_dev_model #(
  parameter logic [6:0] OWN_ADDR = 7'h51
) (
  input  logic        scl,
  input  logic        sda,
  input  logic        absent,
  input  logic [15:0] stretch_ns,
  output logic        sda_pull,
  output logic        scl_pull,
  output int          starts,
  output int          stops
);
  localparam int M_IDLE = 0;
  localparam int M_ADDR = 1;
  localparam int M_PTR  = 2;
  localparam int M_WR   = 3;
  localparam int M_RD   = 4;
  logic [7:0] mem [256];
  logic [7:0] ptr;
  logic [7:0] sh;
  logic [7:0] tx;
  logic       mack;
  logic       prev_scl;
  logic       prev_sda;
  int         bitc;
  int         mode;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Known start contents so reads of untouched registers are still predictable.
  initial begin
    sda_pull = 1'b0;
    scl_pull = 1'b0;
    starts   = 0;
    stops    = 0;
    ptr      = 8'h00;
    mode     = M_IDLE;
    bitc     = 0;
    mack     = 1'b1;
    prev_scl = 1'b1;
    prev_sda = 1'b1;
    foreach (mem[i]) mem[i] = 8'(i) ^ 8'h5a;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // One process sees both lines, so a change with the clock high is never taken as data.
  always @(scl, sda) begin
    if (scl && prev_scl && prev_sda && !sda) begin
      starts++;
      mode     = M_ADDR;
      bitc     = -1; // The clock fall that closes the start carries no data bit.
      sda_pull = 1'b0;
    end else if (scl && prev_scl && !prev_sda && sda) begin
      stops++;
      mode     = M_IDLE;
      sda_pull = 1'b0;
    end else if (scl && !prev_scl && mode != M_IDLE) begin
      if (bitc < 8) sh = {sh[6:0], sda};
      else mack = !sda;
    end else if (!scl && prev_scl && mode != M_IDLE) begin
      bitc++;
      if (bitc == 8) begin
        sda_pull = 1'b0;
        case (mode)
          M_ADDR: if (sh[7:1] == OWN_ADDR && !absent) begin
            sda_pull = 1'b1;
            mode     = sh[0] ? M_RD : M_PTR;
            mack     = 1'b1;
          end else mode = M_IDLE;
          M_PTR: begin
            ptr      = sh;
            sda_pull = 1'b1;
            mode     = M_WR;
          end
          M_WR: begin
            mem[ptr] = sh;
            ptr++;
            sda_pull = 1'b1;
          end
          default: ;
        endcase
      end else if (bitc == 9) begin
        sda_pull = 1'b0;
        bitc     = 0;
        if (mode == M_RD && !mack) mode = M_IDLE;
        else if (mode == M_RD) begin
          tx       = mem[ptr];
          ptr++;
          sda_pull = !tx[7];
        end
      end else if (mode == M_RD) sda_pull = !tx[3'(7 - bitc)];
    end
    prev_scl = scl;
    prev_sda = sda;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Slow device: holds the clock low after each fall, which the host must wait out.
  always @(negedge scl) begin
    if (stretch_ns != 16'h0000) begin
      scl_pull = 1'b1;
      #(stretch_ns) scl_pull = 0;
    end
  end
endmodule

// File: sim/rtcm_i2c_host_test.sv
// Self-checking bench for the two-wire host talking to the clock chip model.
// Assumes the host's quarter-bit count can be shortened to 8 clocks for a quick run.
`timescale 1ns/100ps
module rtcm_i2c_host_test;
  logic                 clk        = 1'b0;
  logic                 reset      = 1'b1;
  logic                 cmd_valid  = 1'b0;
  logic                 wr_valid   = 1'b0;
  logic                 absent     = 1'b0;
  logic [7:0]           wr_data    = 8'h00;
  logic [15:0]          stretch_ns = 16'h0000;
  rtcm_pkg::rtcm_cmd_t  cmd        = '0;
  logic                 cmd_ready, wr_ready, rd_valid, busy;
  logic                 scl_o, scl_oe, sda_o, sda_oe, sda_pull, scl_pull;
  logic [7:0]           rd_data;
  logic [7:0]           cur_ptr;
  rtcm_pkg::rtcm_resp_t resp;
  int                   starts, stops, j;
  int                   miscompares = 0;
  int                   comparisons = 0;
  int                   seed        = 32'hb7b1;
  logic [7:0]           exp_mem [256];
  logic [7:0]           rd_q [$];
  logic [7:0]           wr_q [$];
  rtcm_pkg::rtcm_resp_t resp_q [$];
  wire                  scl_line = !(scl_oe | scl_pull);
  wire                  sda_line = !(sda_oe | sda_pull);

  always #25 clk = ~clk;

  rtcm_i2c_host #(.TQ_CYCLES(8)) i_rtcm_i2c_host (.clk(clk), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .rd_valid(rd_valid), .rd_data(rd_data), .resp(resp), .busy(busy), .scl_i(scl_line),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe));

  rtcm_dev_model i_rtcm_dev_model (.scl(scl_line), .sda(sda_line), .absent(absent),
    .stretch_ns(stretch_ns), .sda_pull(sda_pull), .scl_pull(scl_pull), .starts(starts),
    .stops(stops));

  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Notes the expected bytes and report, issues one command and waits for it under a bound.
  task automatic run(input logic rd, input logic sp, input logic [7:0] p, input logic [7:0] n);
    int         i;
    int         s0;
    int         p0;
    logic [7:0] d;
    s0 = starts;
    p0 = stops;
    if (!rd || sp) cur_ptr = p;
    for (i = 0; i < ((rd && n == 8'h00) ? 1 : int'(n)); i++) begin
      if (!rd) begin
        d = 8'($random(seed));
        wr_q.push_back(d);
        exp_mem[cur_ptr] = d;
      end else if (!absent) rd_q.push_back(exp_mem[cur_ptr]);
      if (!absent) cur_ptr++;
    end
    resp_q.push_back({1'b1, absent});
    @(posedge clk);
    #2 cmd_valid = 1'b1;
    cmd = {rd, sp, p, n};
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (cmd_ready === 1'b1) break;
    end
    if (i == 100) begin
      miscompares++;
      close_out();
    end
    #2 cmd_valid = 1'b0;
    check({7'h00, busy}, 8'h01);
    for (i = 0; i < 40000; i++) begin
      @(posedge clk);
      if (resp.done === 1'b1) break;
    end
    if (i == 40000) begin
      miscompares++;
      close_out();
    end
    #2 check({6'h00, scl_line, sda_line}, 8'h03);
    check({6'h00, scl_o, sda_o}, 8'h00);
    check({7'h00, busy}, 8'h00);
    check(8'(starts - s0), (rd && sp) ? 8'h02 : 8'h01);
    check(8'(stops - p0), 8'h01);
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Feeds write bytes one at a time; the host takes a byte only where it pulses ready.
  always @(posedge clk) begin
    if (wr_valid && wr_ready === 1'b1) void'(wr_q.pop_front());
    #2 wr_valid = wr_q.size() > 0;
    wr_data = (wr_q.size() > 0) ? wr_q[0] : 8'h00;
  end

  // Compares each result with the oldest note as it appears; an unexpected one fails.
  always @(posedge clk) begin
    if (rd_valid === 1'b1) check(rd_data, (rd_q.size() > 0) ? rd_q.pop_front() : ~rd_data);
    if (resp.done === 1'b1)
      check({6'h00, resp}, (resp_q.size() > 0) ? {6'h00, resp_q.pop_front()} : 8'hff);
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    foreach (exp_mem[i]) exp_mem[i] = 8'(i) ^ 8'h5a;
    repeat (2) @(posedge clk);
    #2 reset = 1'b0;
    run(1'b0, 1'b0, 8'h10, 8'h06);
    run(1'b1, 1'b1, 8'h10, 8'h04);
    run(1'b1, 1'b0, 8'h00, 8'h02);
    $display("test write and read-back finished");
    // Random pointers and lengths, alternately with a device that stretches the clock.
    for (j = 0; j < 4; j++) begin
      stretch_ns = j[0] ? 16'd1000 : 16'd0;
      run(1'b0, 1'b0, 8'($random(seed)), 8'(1 + ($random(seed) & 7)));
      run(1'b1, 1'b1, cur_ptr - 8'h03, 8'h03);
    end
    stretch_ns = 16'h0000;
    $display("test random transfers finished");
    run(1'b0, 1'b0, 8'h40, 8'h00);
    run(1'b1, 1'b0, 8'h00, 8'h00);
    $display("test pointer-only write finished");
    absent = 1'b1;
    run(1'b1, 1'b0, 8'h00, 8'h03);
    absent = 1'b0;
    run(1'b1, 1'b0, 8'h00, 8'h01);
    $display("test silent device finished");
    close_out();
  end
endmodule
